// ==== boundary_scan_tap_core.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Reset exits only through Run-Test/Idle, stable.
// - Selector operations run only in Run-Test/Idle.
// - Select states do nothing, leave next cycle.
// - Data capture loads on exiting rising edge.
// - Data shift drives register LSB from falling edge.
// - One bit per cycle, none on entry.
// - First exit state floats TDO on falling edge.
// - Exit back to shift keeps partial contents.
// - Pause states hold contents indefinitely.
// - Data update latches on falling edge.
// - Instruction capture loads fixed status pattern.
// - Instruction update latches on falling edge.
// - Shift stage plus shadow latch, except bypass/id.
// - Eight-bit instruction selects mode and register.
// - Bit 7 even parity; unknown means bypass.
// - Reset state loads identification-read opcode.
// - 48 cells scanned TDI, bit 47 to 0, TDO.
// - Instruction picks capture source; idle may change.
// - Cells 47..44 reset to one.
// - Bits 35..18 A side, 17..0 B side.
// - Three-bit selector decodes pattern, signature, count; no instruction selects it.
// - Selector unchanged by capture, resets to SIGNATURE_ANALYSIS_OP.
// - TMS high five cycles reaches reset state.
// - Sample on rising, drive outputs on falling.
// - Bypass captures zero.
module boundary_scan_tap_core #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001  // Arbitrary identity value.
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  input  wire logic [47:0] pin_values,
  output logic             test_mode,
  output logic             outputs_highz,
  output logic             clamp_active,
  output logic             run_test_active,
  output logic [47:0]      cell_values
);

  // Tck-domain state.
  logic [1:0]                     rst_sync_r;
  boundary_scan_pkg::tap_state_t  state_r;
  boundary_scan_pkg::tap_state_t  state_nxt;
  logic [7:0]                     ir_shift_r;
  logic [7:0]                     opcode_holder;
  logic                           bypass_r;
  logic [31:0]                    id_shift_r;
  logic [47:0]                    bsr_shift_r;
  logic [47:0]                    pin_scan_chain;
  logic [2:0]                     rts_shift_r;
  logic [2:0]                     run_test_selector;
  logic                           tdo_r;
  logic                           tdo_oe_r;
  logic [47:0]                    pins_tck_r;
  logic                           in_req_s1_r;
  logic                           in_req_s2_r;
  logic                           in_ack_r;
  logic                           out_req_r;
  logic                           out_ack_s1_r;
  logic                           out_ack_s2_r;
  logic [51:0]                    out_snap_r;

  // Clock-domain state.
  logic                           in_req_r;
  logic                           in_ack_s1_r;
  logic                           in_ack_s2_r;
  logic [47:0]                    in_snap_r;
  logic                           out_req_s1_r;
  logic                           out_req_s2_r;
  logic                           out_ack_r;
  logic [51:0]                    out_hold_r;

  // Decoded instruction and combinational selections.
  logic                           tck_rst;
  logic [6:0]                     eff_op;
  boundary_scan_pkg::dr_sel_t     dr_sel;
  logic                           is_extest;
  logic                           is_sample;
  logic                           is_highz;
  logic                           is_clamp;
  logic                           is_run_test;
  logic                           is_readbn;
  logic                           is_readbt;
  logic                           in_shift;
  logic                           dr_out_bit;
  logic                           scan_out_bit;
  logic                           run_op_active;
  logic                           mode_test;
  logic [47:0]                    bsr_capture;
  logic [35:0]                    run_cells;
  logic [35:0]                    run_cells_nxt;

  // Parity-checked opcode; a bad parity opcode acts as bypass.
  function automatic logic [6:0] checked_op(input logic [7:0] op);
    checked_op = (^op) ? boundary_scan_pkg::OP_BYPASS : op[6:0];
  endfunction

  // One step of the 36-cell pattern register over the A and B pin cells.
  function automatic logic [35:0] lfsr_step(input logic [35:0] v);
    lfsr_step = {v[34:0], v[35] ^ v[24]};
  endfunction

  // Reset from the system clock is brought into the test clock domain.
  // The test clock must keep running through reset, or the test logic never sees it.
  // Only the second stage is read, so a metastable first stage cannot reach the logic.
  always_ff @(posedge tck) begin
    rst_sync_r <= {rst_sync_r[0], srst};
  end
  assign tck_rst = rst_sync_r[1];

  // Next tap state from TMS; TMS high from any state reaches reset in five cycles.
  always_comb begin
    unique case (state_r)
      boundary_scan_pkg::ST_RESET: begin
        state_nxt = tms ? boundary_scan_pkg::ST_RESET : boundary_scan_pkg::ST_IDLE;
      end
      boundary_scan_pkg::ST_IDLE: begin
        state_nxt = tms ? boundary_scan_pkg::ST_SEL_DR : boundary_scan_pkg::ST_IDLE;
      end
      boundary_scan_pkg::ST_SEL_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_SEL_IR : boundary_scan_pkg::ST_CAP_DR;
      end
      boundary_scan_pkg::ST_CAP_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT1_DR : boundary_scan_pkg::ST_SHIFT_DR;
      end
      boundary_scan_pkg::ST_SHIFT_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT1_DR : boundary_scan_pkg::ST_SHIFT_DR;
      end
      boundary_scan_pkg::ST_EXIT1_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_UPD_DR : boundary_scan_pkg::ST_PAUSE_DR;
      end
      boundary_scan_pkg::ST_PAUSE_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT2_DR : boundary_scan_pkg::ST_PAUSE_DR;
      end
      boundary_scan_pkg::ST_EXIT2_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_UPD_DR : boundary_scan_pkg::ST_SHIFT_DR;
      end
      boundary_scan_pkg::ST_UPD_DR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_SEL_DR : boundary_scan_pkg::ST_IDLE;
      end
      boundary_scan_pkg::ST_SEL_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_RESET : boundary_scan_pkg::ST_CAP_IR;
      end
      boundary_scan_pkg::ST_CAP_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT1_IR : boundary_scan_pkg::ST_SHIFT_IR;
      end
      boundary_scan_pkg::ST_SHIFT_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT1_IR : boundary_scan_pkg::ST_SHIFT_IR;
      end
      boundary_scan_pkg::ST_EXIT1_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_UPD_IR : boundary_scan_pkg::ST_PAUSE_IR;
      end
      boundary_scan_pkg::ST_PAUSE_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_EXIT2_IR : boundary_scan_pkg::ST_PAUSE_IR;
      end
      boundary_scan_pkg::ST_EXIT2_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_UPD_IR : boundary_scan_pkg::ST_SHIFT_IR;
      end
      boundary_scan_pkg::ST_UPD_IR: begin
        state_nxt = tms ? boundary_scan_pkg::ST_SEL_DR : boundary_scan_pkg::ST_IDLE;
      end
    endcase
  end

  // The sixteen-state controller advances on each rising test clock edge.
  always_ff @(posedge tck) begin
    if (tck_rst) begin
      state_r <= boundary_scan_pkg::ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Instruction decode: mode, operation, register and capture source.
  assign eff_op    = checked_op(opcode_holder);
  assign is_extest = (eff_op == boundary_scan_pkg::OP_EXTEST);
  assign is_sample = (eff_op == boundary_scan_pkg::OP_SAMPLE);
  assign is_highz  = (eff_op == boundary_scan_pkg::OP_HIGHZ);
  assign is_clamp  = (eff_op == boundary_scan_pkg::OP_CLAMP);
  assign is_run_test = (eff_op == boundary_scan_pkg::OP_RUN_TEST);
  assign is_readbn = (eff_op == boundary_scan_pkg::OP_READBN);
  assign is_readbt = (eff_op == boundary_scan_pkg::OP_READBT);
  assign mode_test = is_extest | is_highz | is_clamp | is_run_test | is_readbt;
  // Undefined opcodes fall through to bypass.
  assign dr_sel =
    (is_extest | is_sample | is_readbn | is_readbt) ? boundary_scan_pkg::SEL_BSR :
    (eff_op == boundary_scan_pkg::OP_IDCODE)        ? boundary_scan_pkg::SEL_ID  :
    boundary_scan_pkg::SEL_BYPASS;

  // Pin-sampling instructions capture the pins, boundary reads capture the latches.
  assign bsr_capture = (is_readbn | is_readbt) ? pin_scan_chain : pins_tck_r;

  // Instruction shift stage: status pattern on capture, shift towards TDO.
  always_ff @(posedge tck) begin
    if (state_r == boundary_scan_pkg::ST_CAP_IR) begin
      ir_shift_r <= boundary_scan_pkg::IR_CAPTURE;
    end else if (state_r == boundary_scan_pkg::ST_SHIFT_IR) begin
      ir_shift_r <= {tdi, ir_shift_r[7:1]};
    end
  end

  // Bypass cell: zero on capture, one bit of delay while shifting.
  always_ff @(posedge tck) begin
    if (state_r == boundary_scan_pkg::ST_CAP_DR) begin
      bypass_r <= 1'b0;
    end else if (state_r == boundary_scan_pkg::ST_SHIFT_DR) begin
      bypass_r <= tdi;
    end
  end

  // Identity chain: shift stage only, loaded with the identity value.
  always_ff @(posedge tck) begin
    if (state_r == boundary_scan_pkg::ST_CAP_DR && dr_sel == boundary_scan_pkg::SEL_ID) begin
      id_shift_r <= ID_VALUE;
    end else if (state_r == boundary_scan_pkg::ST_SHIFT_DR && dr_sel == boundary_scan_pkg::SEL_ID) begin
      id_shift_r <= {tdi, id_shift_r[31:1]};
    end
  end

  // Pin scan chain shift stage; TDI enters at bit 47, bit 0 leaves on TDO.
  always_ff @(posedge tck) begin
    if (state_r == boundary_scan_pkg::ST_CAP_DR && dr_sel == boundary_scan_pkg::SEL_BSR) begin
      bsr_shift_r <= bsr_capture;
    end else if (state_r == boundary_scan_pkg::ST_SHIFT_DR && dr_sel == boundary_scan_pkg::SEL_BSR) begin
      bsr_shift_r <= {tdi, bsr_shift_r[47:1]};
    end
  end

  // Run-test selector shift stage; capture leaves it untouched.
  // Keeping capture out means a read-back shows what was last shifted in.
  always_ff @(posedge tck) begin
    if (state_r == boundary_scan_pkg::ST_SHIFT_DR && dr_sel == boundary_scan_pkg::SEL_RTS) begin
      rts_shift_r <= {tdi, rts_shift_r[2:1]};
    end
  end

  // Serial output bit of the register currently in the path.
  assign in_shift = (state_r == boundary_scan_pkg::ST_SHIFT_DR) |
                    (state_r == boundary_scan_pkg::ST_SHIFT_IR);
  assign dr_out_bit =
    (dr_sel == boundary_scan_pkg::SEL_ID)  ? id_shift_r[0]  :
    (dr_sel == boundary_scan_pkg::SEL_BSR) ? bsr_shift_r[0] :
    (dr_sel == boundary_scan_pkg::SEL_RTS) ? rts_shift_r[0] : bypass_r;
  assign scan_out_bit = (state_r == boundary_scan_pkg::ST_SHIFT_IR) ? ir_shift_r[0] : dr_out_bit;

  // TDO changes on the falling edge and is driven only in the shift states.
  // Driving on the falling edge gives the far side half a cycle of settled data.
  always_ff @(negedge tck) begin
    if (tck_rst) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= scan_out_bit;
      tdo_oe_r <= in_shift;
    end
  end
  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // Current instruction latch, reset to the identification read.
  always_ff @(negedge tck) begin
    if (tck_rst || state_r == boundary_scan_pkg::ST_RESET) begin
      opcode_holder <= boundary_scan_pkg::IR_RESET;
    end else if (state_r == boundary_scan_pkg::ST_UPD_IR) begin
      opcode_holder <= ir_shift_r;
    end
  end

  // Run-test selector shadow latch.
  always_ff @(negedge tck) begin
    if (tck_rst || state_r == boundary_scan_pkg::ST_RESET) begin
      run_test_selector <= boundary_scan_pkg::RTS_RESET;
    end else if (state_r == boundary_scan_pkg::ST_UPD_DR && dr_sel == boundary_scan_pkg::SEL_RTS) begin
      run_test_selector <= rts_shift_r;
    end
  end

  // Run-test operations act on the A and B pin cells while idle.
  // Selector codes outside the three operations leave the cells as they are.
  // The signature step folds the synchronised pin snapshot into the pattern.
  assign run_op_active = is_run_test & (state_r == boundary_scan_pkg::ST_IDLE);
  assign run_cells   = pin_scan_chain[boundary_scan_pkg::BSR_A_HI:boundary_scan_pkg::BSR_B_LO];
  assign run_cells_nxt =
    (run_test_selector == boundary_scan_pkg::RTS_PATTERN)   ? lfsr_step(run_cells) :
    (run_test_selector == boundary_scan_pkg::RTS_SIGNATURE) ?
      (lfsr_step(run_cells) ^ pins_tck_r[boundary_scan_pkg::BSR_A_HI:boundary_scan_pkg::BSR_B_LO]) :
    (run_test_selector == boundary_scan_pkg::RTS_COUNT)     ? (run_cells + 36'h0_0000_0001) :
    run_cells;

  // Pin scan chain shadow latches: update, idle operations and output-enable reset.
  always_ff @(negedge tck) begin
    if (tck_rst || state_r == boundary_scan_pkg::ST_RESET) begin
      pin_scan_chain <= boundary_scan_pkg::BSR_RESET;
    end else if (state_r == boundary_scan_pkg::ST_UPD_DR &&
                 dr_sel == boundary_scan_pkg::SEL_BSR && (is_extest | is_sample)) begin
      pin_scan_chain <= bsr_shift_r;
    end else if (run_op_active) begin
      pin_scan_chain[35:0] <= run_cells_nxt;
    end
  end

  // Pin values arrive by toggle handshake; the snapshot is stable while requested.
  // The word itself never crosses unguarded: only the toggle passes two flip-flops.
  always_ff @(posedge tck) begin
    in_req_s1_r <= in_req_r;
    in_req_s2_r <= in_req_s1_r;
    if (tck_rst) begin
      in_ack_r <= 1'b0;
    end else if (in_req_s2_r != in_ack_r) begin
      pins_tck_r <= in_snap_r;
      in_ack_r   <= in_req_s2_r;
    end
  end

  // Mode and cell state are published towards the system clock by handshake.
  always_ff @(posedge tck) begin
    out_ack_s1_r <= out_ack_r;
    out_ack_s2_r <= out_ack_s1_r;
    if (tck_rst) begin
      out_req_r  <= 1'b0;
      out_snap_r <= {4'h0, boundary_scan_pkg::BSR_RESET};
    end else if (out_req_r == out_ack_s2_r) begin
      out_snap_r <= {mode_test, is_highz, is_clamp, run_op_active, pin_scan_chain};
      out_req_r  <= ~out_req_r;
    end
  end

  // System side of the pin-value handshake.
  always_ff @(posedge clock) begin
    in_ack_s1_r <= in_ack_r;
    in_ack_s2_r <= in_ack_s1_r;
    if (srst) begin
      in_req_r  <= 1'b0;
      in_snap_r <= 48'h0000_0000_0000;
    end else if (in_req_r == in_ack_s2_r) begin
      in_snap_r <= pin_values;
      in_req_r  <= ~in_req_r;
    end
  end

  // System side of the published state; outputs come from this register.
  // Users must allow a few cycles of both clocks before a change shows here.
  always_ff @(posedge clock) begin
    out_req_s1_r <= out_req_r;
    out_req_s2_r <= out_req_s1_r;
    if (srst) begin
      out_ack_r  <= 1'b0;
      out_hold_r <= {4'h0, boundary_scan_pkg::BSR_RESET};
    end else if (out_req_s2_r != out_ack_r) begin
      out_hold_r <= out_snap_r;
      out_ack_r  <= out_req_s2_r;
    end
  end

  // Registered outputs towards the transceiver's test logic.
  assign test_mode       = out_hold_r[51];
  assign outputs_highz   = out_hold_r[50];
  assign clamp_active    = out_hold_r[49];
  assign run_test_active = out_hold_r[48];
  assign cell_values     = out_hold_r[47:0];

endmodule

// ==== boundary_scan_pkg.sv ====
package boundary_scan_pkg;

  // Register widths.
  localparam int IR_W  = 8;
  localparam int BSR_W = 48;
  localparam int RTS_W = 3;
  localparam int ID_W  = 32;

  // Instruction reset value and the status pattern loaded during instruction capture.
  localparam logic [7:0] IR_RESET   = 8'h81;
  localparam logic [7:0] IR_CAPTURE = 8'h81;

  // Opcode bits 6..0; bit 7 is the even-parity bit.
  localparam logic [6:0] OP_EXTEST = 7'h00;
  localparam logic [6:0] OP_IDCODE = 7'h01;
  localparam logic [6:0] OP_SAMPLE = 7'h02;
  localparam logic [6:0] OP_BYPASS = 7'h03;
  localparam logic [6:0] OP_HIGHZ  = 7'h06;
  localparam logic [6:0] OP_CLAMP  = 7'h07;
  localparam logic [6:0] OP_RUN_TEST = 7'h09;
  localparam logic [6:0] OP_READBN = 7'h0a;
  localparam logic [6:0] OP_READBT = 7'h0b;

  // Run-test selector reset value and operation codes.
  localparam logic [2:0] RTS_RESET     = 3'h2;
  localparam logic [2:0] RTS_PATTERN   = 3'h1;
  localparam logic [2:0] RTS_SIGNATURE = 3'h2;
  localparam logic [2:0] RTS_COUNT     = 3'h3;

  // Pin scan chain field positions.
  localparam int BSR_OE_HI = 47;
  localparam int BSR_OE_LO = 44;
  localparam int BSR_A_HI  = 35;
  localparam int BSR_A_LO  = 18;
  localparam int BSR_B_HI  = 17;
  localparam int BSR_B_LO  = 0;
  localparam logic [47:0] BSR_RESET = 48'hf000_0000_0000;

  // Tap states, Gray coded along the usual path.
  typedef enum logic [3:0] {
    ST_RESET    = 4'h0,
    ST_IDLE     = 4'h1,
    ST_SEL_DR   = 4'h3,
    ST_CAP_DR   = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR   = 4'hc,
    ST_SEL_IR   = 4'hd,
    ST_CAP_IR   = 4'hf,
    ST_SHIFT_IR = 4'he,
    ST_EXIT1_IR = 4'ha,
    ST_PAUSE_IR = 4'hb,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR   = 4'h8
  } tap_state_t;

  // Data register selected into the scan path.
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_ID     = 2'h1,
    SEL_BSR    = 2'h2,
    SEL_RTS    = 2'h3
  } dr_sel_t;

endpackage

// ==== tap_checker.sv ====
`timescale 1ns/1ns
// Follows the tap state from tms and checks the link and the mode outputs.
module tap_checker (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdi,
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic [47:0] pin_values,
  input wire logic        test_mode,
  input wire logic        outputs_highz,
  input wire logic        clamp_active,
  input wire logic        run_test_active,
  input wire logic [47:0] cell_values
);
  // Next-state tables, one nibble per state code, for tms low and tms high.
  localparam logic [63:0] NXT0 = 64'heef1_bbe1_5656_2611;
  localparam logic [63:0] NXT1 = 64'haa03_9883_c74c_d730;
  logic [3:0] st_r, st_nxt, cnt_r, cnt_nxt, run_r, run_nxt;
  logic       shift_ir, in_shift, may_enter, in_exit1;
  // State decode and counters of instruction shifts.
  assign st_nxt    = tms ? NXT1[{st_r, 2'h0} +: 4] : NXT0[{st_r, 2'h0} +: 4];
  assign shift_ir  = st_r == boundary_scan_pkg::ST_SHIFT_IR;
  assign in_shift  = shift_ir || st_r == boundary_scan_pkg::ST_SHIFT_DR;
  assign in_exit1  = st_r inside {boundary_scan_pkg::ST_EXIT1_DR, boundary_scan_pkg::ST_EXIT1_IR};
  assign may_enter = st_r inside {boundary_scan_pkg::ST_CAP_DR, boundary_scan_pkg::ST_EXIT2_DR,
                                  boundary_scan_pkg::ST_CAP_IR, boundary_scan_pkg::ST_EXIT2_IR};
  assign cnt_nxt   = (st_r == boundary_scan_pkg::ST_CAP_IR) ? 4'h0 :
                     cnt_r + {3'h0, shift_ir && cnt_r < 4'h8};
  assign run_nxt   = shift_ir ? run_r + {3'h0, run_r < 4'hf} : 4'h0;
  // Registers advance on the rising test clock edge, like the controller.
  always_ff @(posedge tck) begin
    if (srst) begin
      st_r  <= 4'h0;
      cnt_r <= 4'h0;
      run_r <= 4'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end
  a_oe_shift_only: assert property (@(posedge tck) disable iff (srst)
    tdo_oe == in_shift) else $error("tdo drive does not match shift state");
  a_ir_status_out: assert property (@(posedge tck) disable iff (srst)
    shift_ir && cnt_r < 4'h8 |-> tdo == boundary_scan_pkg::IR_CAPTURE[cnt_r[2:0]])
    else $error("instruction status bit wrong");
  a_ir_eight_deep: assert property (@(posedge tck) disable iff (srst)
    shift_ir && run_r >= 4'h8 |-> tdo == $past(tdi, 8)) else $error("instruction path length");
  a_oe_rise_cause: assert property (@(posedge tck) disable iff (srst)
    $rose(tdo_oe) |-> $past(may_enter)) else $error("tdo enabled without shift entry");
  a_oe_fall_exit: assert property (@(posedge tck) disable iff (srst)
    $fell(tdo_oe) |-> in_exit1) else $error("tdo released outside first exit");
  a_highz_test: assert property (@(posedge clock) disable iff (srst)
    outputs_highz |-> test_mode) else $error("high impedance outside test mode");
  a_clamp_test: assert property (@(posedge clock) disable iff (srst)
    clamp_active |-> test_mode) else $error("clamp outside test mode");
  a_modes_apart: assert property (@(posedge clock) disable iff (srst)
    !(outputs_highz && clamp_active)) else $error("highz and clamp together");
  a_boundary_run_test_instr_alone: assert property (@(posedge clock) disable iff (srst)
    run_test_active |-> test_mode && !outputs_highz && !clamp_active)
    else $error("run test with wrong modes");
endmodule

bind boundary_scan_tap_core tap_checker chk (
  .clock(clock), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
  .pin_values(pin_values), .test_mode(test_mode), .outputs_highz(outputs_highz),
  .clamp_active(clamp_active), .run_test_active(run_test_active), .cell_values(cell_values)
);

// ==== jtag_master.sv ====
`timescale 1ns/1ns
// Test controller model: one call makes one 32 ns test clock cycle.
// The clock rests low between calls; tms and tdi rest high as their pull-ups hold them.
module jtag_master (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // Idle levels at time zero.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // Drive after the fall, hold across the rise, release after the next fall.
  task automatic step(input logic mode, input logic data);
    tms = mode;
    tdi = data;
    #14 tck = 1'b1;
    #16 tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    #2;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  typedef struct {
    logic [7:0]  op;
    int          len;
    logic [47:0] cap;
    logic [3:0]  modes;
  } row_t;
  localparam logic [31:0] ID   = 32'h0000_5a3c;  // Arbitrary identity value.
  localparam logic [47:0] PINS = 48'h9a5c_3c96_e1f0;
  localparam logic [63:0] DIN  = 64'h0000_8e3c_5a96_b1e7;
  localparam logic [7:0]  HZ   = 8'h06;
  logic        clock, srst, tck, tms, tdi, tdo, tdo_oe;
  logic        test_mode, outputs_highz, clamp_active, run_test_active;
  logic [3:0]  modes;
  logic [47:0] pin_values, cell_values;
  logic [63:0] got, expv;
  int          miscompares, checked;
  // Opcode, scanned length, captured value, and test/highz/clamp/run flags.
  row_t rows [11] = '{
    '{8'h81, 32, {16'h0000, ID}, 4'h0},
    '{8'h03, 1, 48'h0, 4'h0},
    '{8'h04, 1, 48'h0, 4'h0},
    '{8'h89, 1, 48'h0, 4'h0},
    '{8'h06, 1, 48'h0, 4'hc},
    '{8'h87, 1, 48'h0, 4'ha},
    '{8'h09, 1, 48'h0, 4'h9},
    '{8'h82, 48, PINS, 4'h0},
    '{8'h0a, 48, DIN[48:1], 4'h0},
    '{8'h8b, 48, DIN[48:1], 4'h8},
    '{8'h00, 48, PINS, 4'h8}
  };
  assign modes = {test_mode, outputs_highz, clamp_active, run_test_active};
  boundary_scan_tap_core #(.ID_VALUE(ID)) uut (
    .clock(clock), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_values(pin_values), .test_mode(test_mode), .outputs_highz(outputs_highz),
    .clamp_active(clamp_active), .run_test_active(run_test_active), .cell_values(cell_values)
  );
  jtag_master m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // System clock of 40 ns.
  always #20 clock = ~clock;
  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [63:0] seen, input logic [63:0] want, input string what);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Stays in Run-Test/Idle for n test clock cycles.
  task automatic idle(input int n);
    repeat (n) m.step(1'b0, 1'b1);
  endtask
  // One scan from Run-Test/Idle back to Run-Test/Idle, least significant bit first.
  task automatic scan(input logic ir, input int n, input logic [63:0] d, output logic [63:0] q);
    q = 64'h0;
    m.step(1'b1, 1'b1);
    if (ir) m.step(1'b1, 1'b1);
    repeat (2) m.step(1'b0, 1'b1);
    check(tdo_oe, 1'b1, "shift_oe");
    for (int i = 0; i < n; i++) begin
      q[i] = tdo;
      m.step(i == n - 1, d[i]);
    end
    check(tdo_oe, 1'b0, "exit_oe");
    m.step(1'b1, 1'b1);
    m.step(1'b0, 1'b1);
  endtask
  // Cuts a hung run short.
  initial begin
    #1_000_000;
    miscompares++;
    stop_test();
  end
  // Main sequence: reset with the test clock running, the table, then the awkward cases.
  initial begin
    clock       = 1'b0;
    srst        = 1'b1;
    pin_values  = PINS;
    miscompares = 0;
    checked     = 0;
    fork
      repeat (25) m.step(1'b1, 1'b1);
      begin
        repeat (20) @(negedge clock);
        srst <= 1'b0;
      end
    join
    repeat (4) m.step(1'b1, 1'b1);
    check(cell_values[47:44], 4'hf, "reset_cells");
    check(modes, 4'h0, "reset_modes");
    check(tdo_oe, 1'b0, "reset_oe");
    m.step(1'b0, 1'b1);
    foreach (rows[k]) begin
      scan(1'b1, 16, {40'h0, rows[k].op, 8'h5c}, got);
      check(got, 64'h5c81, "status");
      idle(12);
      check(modes, rows[k].modes, "modes");
      expv = {16'h0000, rows[k].cap};
      expv[rows[k].len] = DIN[0];
      scan(1'b0, rows[k].len + 1, DIN, got);
      check(got, expv, "capture");
      if (rows[k].op == 8'h82) begin
        idle(12);
        check(cell_values, DIN[48:1], "latches");
      end
    end
    // Instruction scan paused after four bits, then resumed without a new capture.
    m.step(1'b1, 1'b1);
    m.step(1'b1, 1'b1);
    repeat (2) m.step(1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      got[i] = tdo;
      m.step(i == 3 || i == 7, HZ[i]);
      if (i == 3) begin
        repeat (3) m.step(1'b0, 1'b1);
        check(tdo_oe, 1'b0, "pause_oe");
        m.step(1'b1, 1'b1);
        m.step(1'b0, 1'b1);
      end
    end
    m.step(1'b1, 1'b1);
    m.step(1'b0, 1'b1);
    check(got[7:0], 8'h81, "paused_status");
    idle(12);
    check(modes, 4'hc, "paused_load");
    // Run test leaves idle for a data pause, then five tms-high cycles reset the logic.
    scan(1'b1, 8, 64'h09, got);
    idle(8);
    m.step(1'b1, 1'b1);
    m.step(1'b0, 1'b1);
    m.step(1'b1, 1'b1);
    repeat (12) m.step(1'b0, 1'b1);
    check(modes, 4'h8, "run_outside_idle");
    repeat (5) m.step(1'b1, 1'b1);
    idle(12);
    check(modes, 4'h0, "tms_reset_modes");
    check(cell_values[47:44], 4'hf, "tms_reset_cells");
    scan(1'b0, 32, DIN, got);
    check(got, {32'h0, ID}, "tms_reset_id");
    stop_test();
  end
endmodule
